//--- design/qtw_regs.vh
`ifndef QTW_REGS_VH
`define QTW_REGS_VH

// register byte offsets
`define QTW_OFS_CTRL     12'h000
`define QTW_OFS_MASK     12'h004
`define QTW_OFS_STATUS   12'h008
`define QTW_OFS_MATCH0   12'h00c
`define QTW_OFS_MATCH1   12'h010
`define QTW_OFS_MATCH2   12'h014
`define QTW_OFS_MATCH3   12'h018
`define QTW_OFS_COUNT0   12'h01c
`define QTW_OFS_COUNT1   12'h020
`define QTW_OFS_COUNT2   12'h024
`define QTW_OFS_COUNT3   12'h028
`define QTW_OFS_GUARD    12'h02c
`define QTW_OFS_FEED     12'h030
`define QTW_OFS_GCOUNT   12'h034

// control register fields
`define QTW_CTRL_GATE    0
`define QTW_CTRL_SEL_LO  1
`define QTW_CTRL_SEL_HI  2
`define QTW_CTRL_CHAIN   3
`define QTW_CTRL_RUN_LO  4
`define QTW_CTRL_RUN_HI  7
`define QTW_CTRL_FREE_LO 8
`define QTW_CTRL_FREE_HI 11
`define QTW_CTRL_RESET   12'h000

// status register fields
`define QTW_ST_NMI       4
`define QTW_ST_CAUSE     5

// guard register fields
`define QTW_GD_EN        0
`define QTW_GD_NMI_LO    16
`define QTW_GD_NMI_HI    25
`define QTW_GD_NMI_RESET 10'h200
`define QTW_GD_MAX       10'h3ff

// system clock selection codes
`define QTW_SEL_20MHZ    2'h0
`define QTW_SEL_10MHZ    2'h1
`define QTW_SEL_5MHZ     2'h2

// timing
`define QTW_CLK_KHZ      15'h4e20
`define QTW_LFO_KHZ      15'h016d
`define QTW_TICK_MS      32'h0000000a
`define QTW_GUARD_DIV    7'h7f
`define QTW_SHORT_W      12
`define QTW_LONG_W       32
`define QTW_GUARD_W      10

`endif

//--- design/qtw_match_timer.v
`timescale 1ns/10ps
`default_nettype none

// one match counter; width is set per instance
module qtw_match_timer
#(
   parameter W = 32
)
(
   input  wire        clk,
   input  wire        reset,
   input  wire        tick,
   input  wire        run,
   input  wire        freeRun,
   input  wire        restart,
   input  wire [31:0] matchVal,
   output wire [31:0] count,
   output wire        hit
);

   reg [W-1:0] cnt_ff;
   reg         halt_ff;
   reg         hit_ff;
   wire        atMatch;

   assign atMatch = (cnt_ff == matchVal[W-1:0]);
   assign count   = {{(32-W){1'b0}}, cnt_ff};
   assign hit     = hit_ff;

   // single shot halts at match, free running wraps to zero
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_ff  <= {W{1'b0}};
         halt_ff <= 1'b0;
         hit_ff  <= 1'b0;
      end
      else if (restart)
      begin
         cnt_ff  <= {W{1'b0}};
         halt_ff <= 1'b0;
         hit_ff  <= 1'b0;
      end
      else
      begin
         hit_ff <= 1'b0;
         if (run && tick && !halt_ff)
         begin
            if (atMatch)
            begin
               hit_ff <= 1'b1;
               cnt_ff <= {W{1'b0}};
               halt_ff <= !freeRun;
            end
            else
               cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // qtw_match_timer

`default_nettype wire

//--- design/qtw_timer_unit.v
// How it works
// - two 12-bit match timers on slow oscillator
// - two 32-bit timers on system clock
// - all configured over 32-bit APB slave
// - short timers tick at oscillator over two
// - long timers tick at the selected system clock rate
// - one match register per timer, no capture
// - all timer events share one output
// - timer one may chain from timer zero
// - short timers: single-shot or free-running
// - long timers: single-shot or free-running
// - match sets flag, each individually masked
// - tick exception every fixed 10 ms
// - unfed guard counter asserts system reset
// - guard enabled by software, off after reset
// - guard 10-bit, oscillator over 128
// - guard interrupt at predefined count value
// - guard interrupt drives non-maskable line
// - slow oscillator runs at 365 kHz
// - system clock select 20/10/5 MHz
// - software gates the timer clock
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "qtw_regs.vh"
`default_nettype none

module qtw_timer_unit
#(
   parameter TICK_CYCLES = `QTW_TICK_MS * `QTW_CLK_KHZ
)
(
   input  wire        clk,
   input  wire        reset,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output wire        timerIrq,
   output wire        tickException,
   output wire        guardNmi,
   output wire        guardReset
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   reg  [11:0] ctrl_ff;
   reg  [3:0]  mask_ff;
   reg  [3:0]  flag_ff;
   reg  [31:0] match_ff [0:3];
   reg         gdEn_ff;
   reg  [9:0]  gdNmiVal_ff;
   reg  [9:0]  gdCnt_ff;
   reg         gdNmi_ff;
   reg         gdCause_ff;
   reg         gdReset_ff;
   reg  [14:0] lfoAcc_ff;
   reg         lfoTick_ff;
   reg         lfoHalf_ff;
   reg  [6:0]  gdDiv_ff;
   reg  [1:0]  sysDiv_ff;
   reg  [17:0] tickCnt_ff;
   reg         tickExc_ff;
   reg         irq_ff;
   reg         pready_ff;
   reg         pslverr_ff;
   reg  [31:0] prdata_ff;
   reg  [31:0] nxt_prdata;
   reg         nxt_pslverr;
   reg  [14:0] nxt_lfoAcc;
   wire        access;
   wire        wrDone;
   wire        gate;
   wire        shortTick;
   wire        longTick;
   wire        gdTick;
   wire [3:0]  hit;
   wire [3:0]  restart;
   wire [31:0] count [0:3];
   wire        wrStatus;
   wire        wrFeed;
   localparam [17:0] TICK_LAST = TICK_CYCLES[17:0] - 18'h00001;

   ////////////////////////////////////////////////////////////////////////////
   // apb handshake: one wait state, effect at the edge where pready is high
   assign access = psel && penable && !pready_ff;
   assign wrDone = psel && penable && pready_ff && pwrite;
   assign wrStatus = wrDone && (paddr == `QTW_OFS_STATUS);
   assign wrFeed   = wrDone && (paddr == `QTW_OFS_FEED);

   // read mux and unmapped detection
   always @*
   begin
      nxt_prdata  = 32'h00000000;
      nxt_pslverr = 1'b0;
      if (paddr == `QTW_OFS_CTRL)
         nxt_prdata = {20'h00000, ctrl_ff};
      else if (paddr == `QTW_OFS_MASK)
         nxt_prdata = {28'h0000000, mask_ff};
      else if (paddr == `QTW_OFS_STATUS)
         nxt_prdata = {26'h0000000, gdCause_ff, gdNmi_ff, flag_ff};
      else if (paddr == `QTW_OFS_MATCH0)
         nxt_prdata = match_ff[0];
      else if (paddr == `QTW_OFS_MATCH1)
         nxt_prdata = match_ff[1];
      else if (paddr == `QTW_OFS_MATCH2)
         nxt_prdata = match_ff[2];
      else if (paddr == `QTW_OFS_MATCH3)
         nxt_prdata = match_ff[3];
      else if (paddr == `QTW_OFS_COUNT0)
         nxt_prdata = count[0];
      else if (paddr == `QTW_OFS_COUNT1)
         nxt_prdata = count[1];
      else if (paddr == `QTW_OFS_COUNT2)
         nxt_prdata = count[2];
      else if (paddr == `QTW_OFS_COUNT3)
         nxt_prdata = count[3];
      else if (paddr == `QTW_OFS_GUARD)
         nxt_prdata = {6'h00, gdNmiVal_ff, 15'h0000, gdEn_ff};
      else if (paddr == `QTW_OFS_GCOUNT)
         nxt_prdata = {22'h000000, gdCnt_ff};
      else if (paddr != `QTW_OFS_FEED)
         nxt_pslverr = 1'b1;                // feed reads zero without error
   end

   // answer registers; data valid together with pready
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end
      else
      begin
         pready_ff  <= access;
         pslverr_ff <= access && nxt_pslverr;
         if (access && !pwrite)
            prdata_ff <= nxt_prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_ff     <= `QTW_CTRL_RESET;
         mask_ff     <= 4'h0;
         match_ff[0] <= 32'h00000000;
         match_ff[1] <= 32'h00000000;
         match_ff[2] <= 32'h00000000;
         match_ff[3] <= 32'h00000000;
         gdNmiVal_ff <= `QTW_GD_NMI_RESET;
      end
      else if (wrDone)
      begin
         if (paddr == `QTW_OFS_CTRL)
            ctrl_ff <= pwdata[11:0];
         else if (paddr == `QTW_OFS_MASK)
            mask_ff <= pwdata[3:0];
         else if (paddr == `QTW_OFS_MATCH0)
            match_ff[0] <= {20'h00000, pwdata[`QTW_SHORT_W-1:0]};
         else if (paddr == `QTW_OFS_MATCH1)
            match_ff[1] <= {20'h00000, pwdata[`QTW_SHORT_W-1:0]};
         else if (paddr == `QTW_OFS_MATCH2)
            match_ff[2] <= pwdata;
         else if (paddr == `QTW_OFS_MATCH3)
            match_ff[3] <= pwdata;
         else if (paddr == `QTW_OFS_GUARD && !gdEn_ff)
            gdNmiVal_ff <= pwdata[`QTW_GD_NMI_HI:`QTW_GD_NMI_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slow oscillator as an exact fractional enable: 365 kHz out of 20 MHz
   always @*
   begin
      nxt_lfoAcc = lfoAcc_ff + `QTW_LFO_KHZ;
      if (nxt_lfoAcc >= `QTW_CLK_KHZ)
         nxt_lfoAcc = nxt_lfoAcc - `QTW_CLK_KHZ;
   end

   // the oscillator runs regardless of the gate so the guard keeps time
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         lfoAcc_ff  <= 15'h0000;
         lfoTick_ff <= 1'b0;
         lfoHalf_ff <= 1'b0;
         gdDiv_ff   <= 7'h00;
         sysDiv_ff  <= 2'h0;
      end
      else
      begin
         sysDiv_ff  <= sysDiv_ff + 2'h1;
         lfoAcc_ff  <= nxt_lfoAcc;
         lfoTick_ff <= (lfoAcc_ff + `QTW_LFO_KHZ >= `QTW_CLK_KHZ);
         if (lfoTick_ff)
         begin
            lfoHalf_ff <= !lfoHalf_ff;
            gdDiv_ff   <= gdDiv_ff + 7'h01;
         end
      end
   end

   assign gate      = ctrl_ff[`QTW_CTRL_GATE];
   assign shortTick = gate && lfoTick_ff && lfoHalf_ff;
   assign gdTick    = lfoTick_ff && (gdDiv_ff == `QTW_GUARD_DIV);

   // system clock rate for the long timers; full rate, half or quarter
   assign longTick = gate &&
      ((ctrl_ff[`QTW_CTRL_SEL_HI:`QTW_CTRL_SEL_LO] == `QTW_SEL_20MHZ) ||
       (ctrl_ff[`QTW_CTRL_SEL_HI:`QTW_CTRL_SEL_LO] == `QTW_SEL_10MHZ &&
        sysDiv_ff[0] == 1'b1) ||
       (ctrl_ff[`QTW_CTRL_SEL_HI:`QTW_CTRL_SEL_LO] == `QTW_SEL_5MHZ &&
        sysDiv_ff == 2'h3));

   ////////////////////////////////////////////////////////////////////////////
   // four match timers; a control write that changes a timer's run bit restarts that timer from zero
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : gTimer
         wire tmTick;
         // only timer one may chain; it then counts timer zero matches
         assign tmTick = (i >= 2) ? longTick :
                         (i == 1 && ctrl_ff[`QTW_CTRL_CHAIN]) ? hit[0] :
                         shortTick;
         assign restart[i] = wrDone && (paddr == `QTW_OFS_CTRL) &&
                             (pwdata[`QTW_CTRL_RUN_LO + i] != ctrl_ff[`QTW_CTRL_RUN_LO + i]);
         qtw_match_timer
         #(
            .W ((i < 2) ? `QTW_SHORT_W : `QTW_LONG_W)
         )
         uTimer
         (
            .clk      (clk),
            .reset    (reset),
            .tick     (tmTick),
            .run      (ctrl_ff[`QTW_CTRL_RUN_LO + i]),
            .freeRun  (ctrl_ff[`QTW_CTRL_FREE_LO + i]),
            .restart  (restart[i]),
            .matchVal (match_ff[i]),
            .count    (count[i]),
            .hit      (hit[i])
         );
         // sticky flag; a match in the clearing cycle wins
         always @(posedge clk or posedge reset)
         begin
            if (reset)
               flag_ff[i] <= 1'b0;
            else if (hit[i])
               flag_ff[i] <= 1'b1;
            else if (wrStatus && pwdata[i])
               flag_ff[i] <= 1'b0;
         end
      end
   endgenerate

   // common output line; mask gates the line, never the flag
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(flag_ff & mask_ff);
   end

   ////////////////////////////////////////////////////////////////////////////
   // periodic tick: one pulse per fixed interval, not affected by the gate
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tickCnt_ff <= 18'h00000;
         tickExc_ff <= 1'b0;
      end
      else if (tickCnt_ff == TICK_LAST)
      begin
         tickCnt_ff <= 18'h00000;
         tickExc_ff <= 1'b1;
      end
      else
      begin
         tickCnt_ff <= tickCnt_ff + 18'h00001;
         tickExc_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // guard counter: enable only by software; expiry resets and disables
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         gdEn_ff    <= 1'b0;
         gdCnt_ff   <= 10'h000;
         gdReset_ff <= 1'b0;
      end
      else
      begin
         gdReset_ff <= 1'b0;
         if (gdEn_ff && gdTick && gdCnt_ff == `QTW_GD_MAX)
         begin
            gdReset_ff <= 1'b1;
            gdEn_ff    <= 1'b0;
            gdCnt_ff   <= 10'h000;
         end
         else if (wrFeed)
            gdCnt_ff <= 10'h000;
         else if (gdEn_ff && gdTick)
            gdCnt_ff <= gdCnt_ff + 10'h001;
         // a write of zero cannot switch the guard off once running
         if (wrDone && paddr == `QTW_OFS_GUARD && pwdata[`QTW_GD_EN])
            gdEn_ff <= 1'b1;
      end
   end

   // nmi flag and reset cause; set wins over a clearing write
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         gdNmi_ff   <= 1'b0;
         gdCause_ff <= 1'b0;
      end
      else
      begin
         // raised on the tick that brings the count onto the preset value
         if (gdEn_ff && gdTick && (gdCnt_ff + 10'h001) == gdNmiVal_ff)
            gdNmi_ff <= 1'b1;
         else if (wrStatus && pwdata[`QTW_ST_NMI])
            gdNmi_ff <= 1'b0;
         if (gdReset_ff)
            gdCause_ff <= 1'b1;
         else if (wrStatus && pwdata[`QTW_ST_CAUSE])
            gdCause_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata        = prdata_ff;
   assign pready        = pready_ff;
   assign pslverr       = pslverr_ff;
   assign timerIrq      = irq_ff;
   assign tickException = tickExc_ff;
   assign guardNmi      = gdNmi_ff;
   assign guardReset    = gdReset_ff;

endmodule // qtw_timer_unit

`default_nettype wire

//--- tb/qtw_timer_unit_properties.sv
`timescale 1ns/10ps
`include "qtw_regs.vh"
`default_nettype none

module qtw_timer_props
#(
   parameter TICK_CYCLES = 50
)
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        timerIrq,
   input wire logic        tickException,
   input wire logic        guardNmi,
   input wire logic        guardReset
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   logic [31:0] gapCnt_ff;
   logic        seenTick_ff;

   // cycles since last tick; first tick only arms the check, its phase is free
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         gapCnt_ff   <= 32'h1;
         seenTick_ff <= 1'b0;
      end
      else
      begin
         gapCnt_ff   <= tickException ? 32'h1 : gapCnt_ff + 32'h1;
         seenTick_ff <= seenTick_ff | tickException;
      end
   end

   ////////////////////////////////////////////////////////////////
   // bus phases
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence

   property p_setup_done;
      s_setup |-> ##2 s_done;
   endproperty
   a_setup_done: assert property (p_setup_done) else $error("late bus answer");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
   property p_ready_qual;
      pready |-> psel && penable;
   endproperty
   a_ready_qual: assert property (p_ready_qual) else $error("ready outside access");
   property p_err_map;
      pready && paddr > `QTW_OFS_GCOUNT |-> pslverr;
   endproperty
   a_err_map: assert property (p_err_map) else $error("unmapped not refused");
   property p_err_data;
      pslverr && !pwrite |-> pready && prdata == 32'h0;
   endproperty
   a_err_data: assert property (p_err_data) else $error("refused read data");
   property p_tick_period;
      tickException && seenTick_ff |-> gapCnt_ff == TICK_CYCLES;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick period");
   property p_irq_clear;
      $fell(timerIrq) |-> $past(pready && pwrite, 2);
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq dropped alone");
   property p_nmi_sticky;
      $fell(guardNmi) |-> $past(pready && pwrite) || $past(pready && pwrite, 2);
   endproperty
   a_nmi_sticky: assert property (p_nmi_sticky) else $error("nmi dropped alone");
   property p_greset_pulse;
      guardReset |=> !guardReset;
   endproperty
   a_greset_pulse: assert property (p_greset_pulse) else $error("reset pulse");
endmodule // qtw_timer_props

bind qtw_timer_unit qtw_timer_props #(.TICK_CYCLES(TICK_CYCLES)) qtw_timer_props_i
   (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerIrq(timerIrq), .tickException(tickException),
    .guardNmi(guardNmi), .guardReset(guardReset));

`default_nettype wire

//--- tb/qtw_apb_master.sv
`timescale 1ns/10ps
`default_nettype none

module qtw_apb_master
(
   input  wire logic        clk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [11:0] paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // idle bus from time zero
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h0;
      pwdata  = 32'h0;
   end

   // one transfer, held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err, output logic ok);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 20)
      begin
         @(posedge clk);
         ok = (pready === 1'b1);
         n++;
      end
      q   = prdata;
      err = pslverr;
      // released lines carry garbage, so a stale value cannot pass
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule // qtw_apb_master

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`include "qtw_regs.vh"
`default_nettype none

module tb;
   localparam int TICKS = 50;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr;
   logic        timerIrq, tickException, guardNmi, guardReset;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, lastData;
   logic        lastErr;
   int          errorCnt, nTests, n;

   qtw_timer_unit #(.TICK_CYCLES(TICKS)) qtw_timer_unit_i
      (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
       .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
       .pslverr(pslverr), .timerIrq(timerIrq), .tickException(tickException),
       .guardNmi(guardNmi), .guardReset(guardReset));
   qtw_apb_master qtw_apb_master_i
      (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
       .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////
   task automatic finishTest();
      $display("comparisons %0d mismatches %0d", nTests, errorCnt);
      if (errorCnt == 0 && nTests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic stall();
      errorCnt++;
      finishTest();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic ok;
      qtw_apb_master_i.xfer(w, a, d, lastData, lastErr, ok);
      if (!ok)
         stall();
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(lastData, exp);
   endtask
   // bounded wait on timer irq (0), guard nmi (1) or tick (2)
   task automatic waitSig(input int s, input int lim);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
         if (n > lim)
            stall();
      end
      while (!(s == 0 ? timerIrq : s == 1 ? guardNmi : tickException));
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic scReset();
      rd(`QTW_OFS_CTRL, 32'h0);
      rd(`QTW_OFS_MASK, 32'h0);
      rd(`QTW_OFS_STATUS, 32'h0);
      rd(`QTW_OFS_GUARD, 32'h0200_0000);
      rd(12'h038, 32'h0);
      chk(lastErr, 1);
      bus(1'b1, `QTW_OFS_MATCH0, 32'hffff_ffff);
      rd(`QTW_OFS_MATCH0, 32'hfff);
      bus(1'b1, `QTW_OFS_MATCH2, 32'hffff_ffff);
      rd(`QTW_OFS_MATCH2, 32'hffff_ffff);
      // sysclk codes, chain and free-run bits with timers stopped
      for (int s = 0; s < 3; s++)
      begin
         bus(1'b1, `QTW_OFS_CTRL, 32'h308 | (s << 1));
         rd(`QTW_OFS_CTRL, 32'h308 | (s << 1));
      end
   endtask
   task automatic scOneShot();
      bus(1'b1, `QTW_OFS_MATCH2, 32'd20);
      bus(1'b1, `QTW_OFS_MASK, 32'h4);
      bus(1'b1, `QTW_OFS_CTRL, 32'h41);
      waitSig(0, 60);
      chk(n >= 18 && n <= 26, 1);
      rd(`QTW_OFS_STATUS, 32'h4);
      rd(`QTW_OFS_COUNT2, 32'h0);
      bus(1'b1, `QTW_OFS_MASK, 32'h0);
      repeat (3) @(negedge clk);
      chk(timerIrq, 0);
      rd(`QTW_OFS_STATUS, 32'h4);
      bus(1'b1, `QTW_OFS_STATUS, 32'h4);
      rd(`QTW_OFS_STATUS, 32'h0);
   endtask
   task automatic scFree();
      logic [31:0] v;
      bus(1'b1, `QTW_OFS_MATCH3, 32'd10);
      bus(1'b1, `QTW_OFS_MASK, 32'h8);
      bus(1'b1, `QTW_OFS_CTRL, 32'h881);
      waitSig(0, 40);
      bus(1'b1, `QTW_OFS_STATUS, 32'h8);
      repeat (3) @(negedge clk);
      chk(timerIrq, 0);
      waitSig(0, 14);
      chk(n >= 2 && n <= 12, 1);
      // gate off must freeze the running counter
      bus(1'b1, `QTW_OFS_CTRL, 32'h880);
      bus(1'b0, `QTW_OFS_COUNT3, 32'h0);
      v = lastData;
      repeat (5) @(negedge clk);
      rd(`QTW_OFS_COUNT3, v);
      bus(1'b1, `QTW_OFS_STATUS, 32'hf);
   endtask
   task automatic scShort();
      bus(1'b1, `QTW_OFS_MATCH0, 32'd3);
      bus(1'b1, `QTW_OFS_MASK, 32'h1);
      bus(1'b1, `QTW_OFS_CTRL, 32'h11);
      waitSig(0, 700);
      chk(n > 200 && n < 600, 1);
      rd(`QTW_OFS_COUNT0, 32'h0);
      // chained pair: timer one counts timer zero matches, four short-timer ticks (eight oscillator ticks)
      bus(1'b1, `QTW_OFS_CTRL, 32'h1);
      bus(1'b1, `QTW_OFS_MATCH0, 32'd1);
      bus(1'b1, `QTW_OFS_MATCH1, 32'd1);
      bus(1'b1, `QTW_OFS_MASK, 32'h2);
      bus(1'b1, `QTW_OFS_CTRL, 32'h139);
      waitSig(0, 600);
      chk(n > 300 && n < 480, 1);
      // stop both before clearing, timer zero would keep flagging
      bus(1'b1, `QTW_OFS_CTRL, 32'h1);
      bus(1'b1, `QTW_OFS_STATUS, 32'hf);
   endtask
   task automatic scGuard();
      bus(1'b1, `QTW_OFS_GUARD, 32'h0001_0001);
      bus(1'b1, `QTW_OFS_GUARD, 32'h0);
      rd(`QTW_OFS_GUARD, 32'h0001_0001);
      waitSig(1, 9000);
      rd(`QTW_OFS_STATUS, 32'h10);
      rd(`QTW_OFS_GCOUNT, 32'h1);
      bus(1'b1, `QTW_OFS_FEED, 32'h0);
      rd(`QTW_OFS_GCOUNT, 32'h0);
      chk(guardReset, 0);
      bus(1'b1, `QTW_OFS_STATUS, 32'h10);
      repeat (3) @(negedge clk);
      chk(guardNmi, 0);
   endtask
   task automatic scTick();
      waitSig(2, 200);
      waitSig(2, 200);
      chk(n, TICKS);
   endtask

   // reset, then every scenario in turn
   initial
   begin
      errorCnt = 0;
      nTests = 0;
      reset = 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      scReset();
      scOneShot();
      scFree();
      scShort();
      scGuard();
      scTick();
      finishTest();
   end
endmodule // tb

`default_nettype wire
